// file: common/gyr_pkg.sv
/*
  Shared constants and types for the angular rate readout: register map, field
  positions, reset values, bandwidth codes, filter figures and host timing.
  Assumes a single 20 MHz clock on both ends of the register link.
*/
package gyr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RATE_W = 16;
  localparam int AXES = 3;
  localparam int FULL_SCALE_W = 3;
  localparam int BANDWIDTH_W = 4;

  // register map, byte addresses
  localparam logic [7:0] X_AXIS_LOW_BYTE_ADDR = 8'h02;
  localparam logic [7:0] X_AXIS_HIGH_BYTE_ADDR = 8'h03;
  localparam logic [7:0] Y_AXIS_LOW_BYTE_ADDR = 8'h04;
  localparam logic [7:0] Y_AXIS_HIGH_BYTE_ADDR = 8'h05;
  localparam logic [7:0] Z_AXIS_LOW_BYTE_ADDR = 8'h06;
  localparam logic [7:0] Z_AXIS_HIGH_BYTE_ADDR = 8'h07;
  localparam logic [7:0] AXIS_ADDR_STRIDE = 8'h02;
  localparam logic [7:0] DIE_THERMAL_READING_ADDR = 8'h08;
  localparam logic [7:0] FULL_SCALE_SELECT_ADDR = 8'h0f;
  localparam logic [7:0] FILTER_BANDWIDTH_SELECT_ADDR = 8'h10;
  localparam logic [7:0] DATA_PATH_OPTIONS_ADDR = 8'h13;
  localparam logic [7:0] SOFTWARE_RESET_TRIGGER_ADDR = 8'h14;
  localparam logic [7:0] SOFT_RESET_CODE = 8'hb6;

  // fields and defaults
  localparam int UNFILTERED_SELECT_BIT = 7;
  localparam int SHADOW_DISABLE_BIT = 6;
  localparam logic [2:0] FULL_SCALE_RESET = 3'h0;
  localparam logic [3:0] BANDWIDTH_RESET = 4'h0;
  localparam logic UNFILTERED_SELECT_RESET = 1'b0;
  localparam logic SHADOW_DISABLE_RESET = 1'b0;

  // bandwidth codes
  localparam logic [3:0] BW_100HZ_WIDE = 4'h7;
  localparam logic [3:0] BW_200HZ_WIDE = 4'h6;
  localparam logic [3:0] BW_100HZ_NARROW = 4'h5;
  localparam logic [3:0] BW_200HZ_NARROW = 4'h4;
  localparam logic [3:0] BW_400HZ = 4'h3;
  localparam logic [3:0] BW_1000HZ = 4'h2;
  localparam logic [3:0] BW_2000HZ = 4'h1;
  localparam logic [3:0] BW_UNFILTERED = 4'h0;

  // decimation factors and their Q16 reciprocals
  localparam logic [4:0] DEC_20 = 5'h14;
  localparam logic [4:0] DEC_10 = 5'h0a;
  localparam logic [4:0] DEC_5 = 5'h05;
  localparam logic [4:0] DEC_2 = 5'h02;
  localparam logic [4:0] DEC_1 = 5'h01;
  localparam logic [16:0] RECIP_20 = 17'h00ccc;
  localparam logic [16:0] RECIP_10 = 17'h0199a;
  localparam logic [16:0] RECIP_5 = 17'h03333;
  localparam logic [16:0] RECIP_2 = 17'h08000;
  localparam logic [16:0] RECIP_1 = 17'h10000;
  localparam int ACC_W = 21;
  localparam int IIR_SHIFT_WIDE = 1;
  localparam int IIR_SHIFT_NARROW = 2;

  // host timing
  localparam longint CLK_HZ = 20000000;
  localparam longint SOFT_RESET_WAIT_MS = 200;
  localparam int unsigned SOFT_RESET_WAIT_CYCLES =
    int'(SOFT_RESET_WAIT_MS * CLK_HZ / 1000);

  typedef enum logic [0:0] {
    GYR_DP_IDLE = 1'b0,
    GYR_DP_AXIS = 1'b1
  } gyr_dp_state_t;

  typedef enum logic [1:0] {
    GYR_HOST_IDLE = 2'b00,
    GYR_HOST_WAIT_LOW = 2'b01,
    GYR_HOST_WAIT_HIGH = 2'b10,
    GYR_HOST_RESET_WAIT = 2'b11
  } gyr_host_state_t;
endpackage

// file: common/gyr_link_if.sv
/*
  Register link between the host controller and the rate readout device.
  Assumes both ends run on the same clock; the testbench joins them.
*/
`timescale 1ns/1ps
interface gyr_link_if;
  logic req_valid;
  logic req_write;
  logic [gyr_pkg::ADDR_W-1:0] req_addr;
  logic [gyr_pkg::DATA_W-1:0] req_wdata;
  logic rsp_valid;
  logic [gyr_pkg::DATA_W-1:0] rsp_data;
  logic protocol_select;

  modport host_mp(
    output req_valid, req_write, req_addr, req_wdata, protocol_select,
    input rsp_valid, rsp_data
  );
  modport dev_mp(
    input req_valid, req_write, req_addr, req_wdata, protocol_select,
    output rsp_valid, rsp_data
  );
endinterface

// file: rtl/gyr_dev.sv
/*
  Device end: register file, two-entry sample buffer, decimating filter,
  IIR stage and shadowed rate byte registers for three axes.
  Assumes front-end samples arrive on the user side with valid/ready and the
  host drives the register link on the same clock.
*/
// Notes on behaviour
// - writing 0xb6 to 0x14 soft-resets
// - soft reset restores configuration defaults
// - host waits 200 ms after soft reset
// - power-on reset loads every default
// - rate word splits high and low bytes
// - rate bytes at 0x02 to 0x07
// - host reads low byte before high
// - low read freezes high until read
// - bit 6 of 0x13 disables shadowing
// - unshadowed, both bytes update per sample
// - decimating filter then IIR filter
// - decimation factors 2, 5, 10, 20
// - bit 7 of 0x13 selects unfiltered
// - codes 7,5 decimate 20; 6,4 decimate 10
// - 3 by 5, 2 by 2, 1/0 full rate
// - bits 2:0 of 0x0f pick full scale
// - 0x08 holds 8-bit die temperature
// - zero at rest, positive on rotation
// - protocol select held low for link
`timescale 1ns/1ps
module gyr_dev (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register link
  gyr_link_if.dev_mp link,
  // front-end samples
  input wire logic sample_valid_in,
  input wire logic [gyr_pkg::RATE_W-1:0] sample_x_in,
  input wire logic [gyr_pkg::RATE_W-1:0] sample_y_in,
  input wire logic [gyr_pkg::RATE_W-1:0] sample_z_in,
  input wire logic [7:0] temp_in,
  output logic sample_ready_out,
  // configuration seen by the front end
  output logic [gyr_pkg::FULL_SCALE_W-1:0] full_scale_out,
  output logic soft_reset_out
);
  import gyr_pkg::*;

  localparam int WORD_W = 3 * RATE_W + 8;

  // register link decode
  logic req_fire;
  logic rd_fire;
  logic wr_fire;
  logic soft_reset_hit;
  assign req_fire = link.req_valid && !link.protocol_select;
  assign rd_fire = req_fire && !link.req_write;
  assign wr_fire = req_fire && link.req_write;
  assign soft_reset_hit = wr_fire && link.req_addr == SOFTWARE_RESET_TRIGGER_ADDR
    && link.req_wdata == SOFT_RESET_CODE;

  // configuration registers
  logic [FULL_SCALE_W-1:0] full_scale_reg;
  logic [BANDWIDTH_W-1:0] bandwidth_code_reg;
  logic unfiltered_select_reg;
  logic shadow_disable_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      full_scale_reg <= FULL_SCALE_RESET;
      bandwidth_code_reg <= BANDWIDTH_RESET;
      unfiltered_select_reg <= UNFILTERED_SELECT_RESET;
      shadow_disable_reg <= SHADOW_DISABLE_RESET;
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= soft_reset_hit;
      if (soft_reset_hit) begin
        full_scale_reg <= FULL_SCALE_RESET;
        bandwidth_code_reg <= BANDWIDTH_RESET;
        unfiltered_select_reg <= UNFILTERED_SELECT_RESET;
        shadow_disable_reg <= SHADOW_DISABLE_RESET;
      end else if (wr_fire) begin
        if (link.req_addr == FULL_SCALE_SELECT_ADDR) begin
          full_scale_reg <= link.req_wdata[FULL_SCALE_W-1:0];
        end
        if (link.req_addr == FILTER_BANDWIDTH_SELECT_ADDR) begin
          bandwidth_code_reg <= link.req_wdata[BANDWIDTH_W-1:0];
        end
        if (link.req_addr == DATA_PATH_OPTIONS_ADDR) begin
          unfiltered_select_reg <= link.req_wdata[UNFILTERED_SELECT_BIT];
          shadow_disable_reg <= link.req_wdata[SHADOW_DISABLE_BIT];
        end
      end
    end
  end
  assign full_scale_out = full_scale_reg;

  // two-entry sample buffer
  logic [WORD_W-1:0] buf_mem [2];
  logic buf_wr_ptr_reg;
  logic buf_rd_ptr_reg;
  logic [1:0] buf_count_reg;
  logic [1:0] buf_count_next;
  logic buf_push;
  logic buf_pop;
  logic buf_valid;
  logic dp_take;
  assign buf_valid = buf_count_reg != 2'h0;
  assign buf_push = sample_valid_in && sample_ready_out;
  assign buf_pop = buf_valid && dp_take;
  assign buf_count_next = 2'(buf_count_reg + {1'b0, buf_push} - {1'b0, buf_pop});

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
      buf_count_reg <= 2'h0;
      sample_ready_out <= 1'b1;
    end else begin
      buf_count_reg <= buf_count_next;
      sample_ready_out <= buf_count_next != 2'h2;
      if (buf_push) begin
        buf_wr_ptr_reg <= !buf_wr_ptr_reg;
      end
      if (buf_pop) begin
        buf_rd_ptr_reg <= !buf_rd_ptr_reg;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (buf_push) begin
      buf_mem[buf_wr_ptr_reg] <= {temp_in, sample_z_in, sample_y_in, sample_x_in};
    end
  end

  // filter selection
  logic [4:0] dec_factor;
  logic [16:0] dec_recip;
  logic iir_narrow;
  logic filt_bypass;
  assign dec_factor = (bandwidth_code_reg == BW_100HZ_WIDE
      || bandwidth_code_reg == BW_100HZ_NARROW) ? DEC_20 :
    (bandwidth_code_reg == BW_200HZ_WIDE || bandwidth_code_reg == BW_200HZ_NARROW) ? DEC_10 :
    (bandwidth_code_reg == BW_400HZ) ? DEC_5 :
    (bandwidth_code_reg == BW_1000HZ) ? DEC_2 : DEC_1;
  assign dec_recip = (dec_factor == DEC_20) ? RECIP_20 :
    (dec_factor == DEC_10) ? RECIP_10 :
    (dec_factor == DEC_5) ? RECIP_5 :
    (dec_factor == DEC_2) ? RECIP_2 : RECIP_1;
  assign iir_narrow = bandwidth_code_reg == BW_100HZ_NARROW
    || bandwidth_code_reg == BW_200HZ_NARROW;
  assign filt_bypass = unfiltered_select_reg || bandwidth_code_reg == BW_UNFILTERED
    || bandwidth_code_reg[3];

  // data path, one axis per cycle
  gyr_dp_state_t dp_state_reg;
  logic [1:0] axis_reg;
  logic [4:0] dec_cnt_reg;
  logic [RATE_W-1:0] cur_reg [AXES];
  logic [ACC_W-1:0] acc_reg [AXES];
  logic [RATE_W-1:0] iir_reg [AXES];
  logic [7:0] temp_reg;
  logic [WORD_W-1:0] buf_head;
  logic [RATE_W-1:0] cur_sample;
  logic [ACC_W-1:0] acc_sum;
  logic dec_last;
  logic signed [ACC_W+17:0] avg_prod;
  logic [RATE_W-1:0] avg_val;
  logic signed [RATE_W:0] iir_diff;
  logic signed [RATE_W:0] iir_step;
  logic [RATE_W-1:0] iir_new;
  logic [RATE_W-1:0] pub_val;
  logic pub_now;

  // no pop on a soft reset cycle: the data path drops its load then
  assign dp_take = dp_state_reg == GYR_DP_IDLE && !soft_reset_hit;
  assign buf_head = buf_mem[buf_rd_ptr_reg];
  assign cur_sample = cur_reg[axis_reg];
  assign acc_sum = acc_reg[axis_reg] + {{(ACC_W-RATE_W){cur_sample[RATE_W-1]}}, cur_sample};
  assign dec_last = dec_cnt_reg >= 5'(dec_factor - DEC_1);
  assign avg_prod = $signed(acc_sum) * $signed({1'b0, dec_recip});
  assign avg_val = avg_prod[RATE_W+15:16];
  assign iir_diff = $signed({avg_val[RATE_W-1], avg_val})
    - $signed({iir_reg[axis_reg][RATE_W-1], iir_reg[axis_reg]});
  assign iir_step = iir_narrow ? (iir_diff >>> IIR_SHIFT_NARROW) : (iir_diff >>> IIR_SHIFT_WIDE);
  assign iir_new = 16'(iir_reg[axis_reg] + iir_step[RATE_W-1:0]);
  assign pub_val = filt_bypass ? cur_sample : iir_new;
  assign pub_now = dp_state_reg == GYR_DP_AXIS && (filt_bypass || dec_last);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dp_state_reg <= GYR_DP_IDLE;
      axis_reg <= 2'h0;
      dec_cnt_reg <= 5'h00;
      temp_reg <= 8'h00;
      for (int i = 0; i < AXES; i++) begin
        cur_reg[i] <= 16'h0000;
        acc_reg[i] <= 21'h000000;
        iir_reg[i] <= 16'h0000;
      end
    end else if (soft_reset_hit) begin
      dp_state_reg <= GYR_DP_IDLE;
      axis_reg <= 2'h0;
      dec_cnt_reg <= 5'h00;
      for (int i = 0; i < AXES; i++) begin
        acc_reg[i] <= 21'h000000;
        iir_reg[i] <= 16'h0000;
      end
    end else begin
      case (dp_state_reg)
        GYR_DP_IDLE: begin
          if (buf_valid) begin
            cur_reg[0] <= buf_head[RATE_W-1:0];
            cur_reg[1] <= buf_head[2*RATE_W-1:RATE_W];
            cur_reg[2] <= buf_head[3*RATE_W-1:2*RATE_W];
            temp_reg <= buf_head[WORD_W-1:3*RATE_W];
            axis_reg <= 2'h0;
            dp_state_reg <= GYR_DP_AXIS;
          end
        end
        GYR_DP_AXIS: begin
          if (!filt_bypass) begin
            acc_reg[axis_reg] <= dec_last ? 21'h000000 : acc_sum;
            if (dec_last) begin
              iir_reg[axis_reg] <= iir_new;
            end
          end
          if (axis_reg == 2'(AXES - 1)) begin
            dp_state_reg <= GYR_DP_IDLE;
            dec_cnt_reg <= (filt_bypass || dec_last) ? 5'h00 : 5'(dec_cnt_reg + 5'h01);
          end else begin
            axis_reg <= 2'(axis_reg + 2'h1);
          end
        end
        default: dp_state_reg <= GYR_DP_IDLE;
      endcase
    end
  end

  // rate byte registers with per-axis shadow lock
  logic [7:0] rate_low_reg [AXES];
  logic [7:0] rate_high_reg [AXES];
  logic [AXES-1:0] lock_reg;
  logic [AXES-1:0] low_hit;
  logic [AXES-1:0] high_hit;

  for (genvar g = 0; g < AXES; g++) begin : g_axis
    logic pub_hit;
    assign low_hit[g] = rd_fire
      && link.req_addr == 8'(X_AXIS_LOW_BYTE_ADDR + 8'(g) * AXIS_ADDR_STRIDE);
    assign high_hit[g] = rd_fire
      && link.req_addr == 8'(X_AXIS_HIGH_BYTE_ADDR + 8'(g) * AXIS_ADDR_STRIDE);
    assign pub_hit = pub_now && axis_reg == 2'(g);

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        rate_low_reg[g] <= 8'h00;
        rate_high_reg[g] <= 8'h00;
        lock_reg[g] <= 1'b0;
      end else begin
        if (soft_reset_hit || shadow_disable_reg || high_hit[g]) begin
          lock_reg[g] <= 1'b0;
        end else if (low_hit[g]) begin
          lock_reg[g] <= 1'b1;
        end
        if (pub_hit) begin
          rate_low_reg[g] <= pub_val[7:0];
          if (!lock_reg[g] || shadow_disable_reg) begin
            rate_high_reg[g] <= pub_val[15:8];
          end
        end
      end
    end
  end

  // read answer, one cycle after the request
  logic [7:0] rd_mux;
  logic [7:0] options_view;
  assign options_view = {unfiltered_select_reg, shadow_disable_reg, 6'h00};
  assign rd_mux = low_hit[0] ? rate_low_reg[0] :
    high_hit[0] ? rate_high_reg[0] :
    low_hit[1] ? rate_low_reg[1] :
    high_hit[1] ? rate_high_reg[1] :
    low_hit[2] ? rate_low_reg[2] :
    high_hit[2] ? rate_high_reg[2] :
    (link.req_addr == DIE_THERMAL_READING_ADDR) ? temp_reg :
    (link.req_addr == FULL_SCALE_SELECT_ADDR) ? {5'h00, full_scale_reg} :
    (link.req_addr == FILTER_BANDWIDTH_SELECT_ADDR) ? {4'h0, bandwidth_code_reg} :
    (link.req_addr == DATA_PATH_OPTIONS_ADDR) ? options_view : 8'h00;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      link.rsp_valid <= 1'b0;
      link.rsp_data <= 8'h00;
    end else begin
      link.rsp_valid <= rd_fire;
      if (rd_fire) begin
        link.rsp_data <= rd_mux;
      end
    end
  end
endmodule

// file: rtl/gyr_host.sv
/*
  Host end: turns user commands into register link requests, reads a rate
  word low byte first, and holds off after a soft reset.
  Assumes the device answers every read exactly one cycle after taking it.
*/
`timescale 1ns/1ps
module gyr_host #(
  parameter int unsigned RESET_WAIT_CYCLES = gyr_pkg::SOFT_RESET_WAIT_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register link
  gyr_link_if.host_mp link,
  // user commands
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic cmd_word_in,
  input wire logic [gyr_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic [gyr_pkg::DATA_W-1:0] cmd_wdata_in,
  output logic cmd_ready_out,
  // results
  output logic result_valid_out,
  output logic [gyr_pkg::RATE_W-1:0] result_data_out,
  output logic reset_wait_out
);
  import gyr_pkg::*;

  gyr_host_state_t state_reg;
  logic [31:0] wait_cnt_reg;
  logic [7:0] low_byte_reg;
  logic word_reg;
  logic cmd_take;
  logic cmd_soft_reset;
  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign cmd_soft_reset = cmd_write_in && cmd_addr_in == SOFTWARE_RESET_TRIGGER_ADDR
    && cmd_wdata_in == SOFT_RESET_CODE;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= GYR_HOST_IDLE;
      wait_cnt_reg <= 32'h00000000;
      low_byte_reg <= 8'h00;
      word_reg <= 1'b0;
      cmd_ready_out <= 1'b1;
      result_valid_out <= 1'b0;
      result_data_out <= 16'h0000;
      reset_wait_out <= 1'b0;
      link.req_valid <= 1'b0;
      link.req_write <= 1'b0;
      link.req_addr <= 8'h00;
      link.req_wdata <= 8'h00;
      link.protocol_select <= 1'b0;
    end else begin
      link.req_valid <= 1'b0;
      result_valid_out <= 1'b0;
      case (state_reg)
        GYR_HOST_IDLE: begin
          if (cmd_take) begin
            link.req_valid <= 1'b1;
            link.req_write <= cmd_write_in;
            link.req_addr <= cmd_addr_in;
            link.req_wdata <= cmd_wdata_in;
            word_reg <= cmd_word_in;
            if (cmd_soft_reset) begin
              cmd_ready_out <= 1'b0;
              reset_wait_out <= 1'b1;
              wait_cnt_reg <= RESET_WAIT_CYCLES;
              state_reg <= GYR_HOST_RESET_WAIT;
            end else if (!cmd_write_in) begin
              cmd_ready_out <= 1'b0;
              state_reg <= GYR_HOST_WAIT_LOW;
            end
          end
        end
        GYR_HOST_WAIT_LOW: begin
          if (link.rsp_valid) begin
            if (word_reg) begin
              low_byte_reg <= link.rsp_data;
              link.req_valid <= 1'b1;
              link.req_write <= 1'b0;
              link.req_addr <= 8'(link.req_addr + 8'h01);
              state_reg <= GYR_HOST_WAIT_HIGH;
            end else begin
              result_valid_out <= 1'b1;
              result_data_out <= {8'h00, link.rsp_data};
              cmd_ready_out <= 1'b1;
              state_reg <= GYR_HOST_IDLE;
            end
          end
        end
        GYR_HOST_WAIT_HIGH: begin
          if (link.rsp_valid) begin
            result_valid_out <= 1'b1;
            result_data_out <= {link.rsp_data, low_byte_reg};
            cmd_ready_out <= 1'b1;
            state_reg <= GYR_HOST_IDLE;
          end
        end
        GYR_HOST_RESET_WAIT: begin
          if (wait_cnt_reg <= 32'h00000001) begin
            reset_wait_out <= 1'b0;
            cmd_ready_out <= 1'b1;
            state_reg <= GYR_HOST_IDLE;
          end else begin
            wait_cnt_reg <= 32'(wait_cnt_reg - 32'h00000001);
          end
        end
        default: state_reg <= GYR_HOST_IDLE;
      endcase
    end
  end
endmodule

// file: sim/gyr_link_chk.sv
/*
  Link checker: request and answer timing, configuration readback.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module gyr_link_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link signals
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [gyr_pkg::ADDR_W-1:0] req_addr,
  input wire logic [gyr_pkg::DATA_W-1:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [gyr_pkg::DATA_W-1:0] rsp_data,
  input wire logic protocol_select
);
  import gyr_pkg::*;
  logic rd_reg;
  logic [7:0] addr_reg;
  logic [2:0] range_reg;
  logic [3:0] bw_reg;
  logic [1:0] opt_reg;
  wire take = req_valid && !protocol_select;
  wire wr = take && req_write;
  wire srst = wr && req_addr == SOFTWARE_RESET_TRIGGER_ADDR && req_wdata == SOFT_RESET_CODE;
  wire wr_opt = wr && req_addr == DATA_PATH_OPTIONS_ADDR;

  // mirror of the writable settings
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_reg <= 1'b0;
      addr_reg <= 8'h00;
      range_reg <= FULL_SCALE_RESET;
      bw_reg <= BANDWIDTH_RESET;
      opt_reg <= 2'h0;
    end else begin
      rd_reg <= take && !req_write;
      addr_reg <= req_addr;
      if (srst || (wr && req_addr == FULL_SCALE_SELECT_ADDR))
        range_reg <= srst ? FULL_SCALE_RESET : req_wdata[2:0];
      if (srst || (wr && req_addr == FILTER_BANDWIDTH_SELECT_ADDR))
        bw_reg <= srst ? BANDWIDTH_RESET : req_wdata[3:0];
      if (srst || wr_opt)
        opt_reg <= srst ? 2'h0 : req_wdata[7:6];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_read_answer; take && !req_write |=> rsp_valid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read unanswered");
  property p_rsp_cause; rsp_valid |-> rd_reg; endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without read");
  property p_write_quiet; wr |=> !rsp_valid; endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("write answered");
  property p_proto_low; !protocol_select; endproperty
  a_proto_low: assert property (p_proto_low) else $error("protocol select high");
  property p_range_rd; rd_reg && addr_reg == 8'h0f |-> rsp_data == {5'h00, range_reg}; endproperty
  a_range_rd: assert property (p_range_rd) else $error("range readback");
  property p_bw_rd; rd_reg && addr_reg == 8'h10 |-> rsp_data == {4'h0, bw_reg}; endproperty
  a_bw_rd: assert property (p_bw_rd) else $error("bandwidth readback");
  property p_opt_rd; rd_reg && addr_reg == 8'h13 |-> rsp_data == {opt_reg, 6'h00}; endproperty
  a_opt_rd: assert property (p_opt_rd) else $error("options readback");
  property p_trig_rd; rd_reg && addr_reg == 8'h14 |-> rsp_data == 8'h00; endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("trigger readback");
  c_soft: cover property (srst);
  c_high: cover property (rd_reg && addr_reg == X_AXIS_HIGH_BYTE_ADDR);
  c_unshadow: cover property (wr_opt && req_wdata[SHADOW_DISABLE_BIT]);
endmodule

// file: sim/gyro_rate_data_readout_bench.sv
/*
  Bench: host and device ends joined by the link, checker beside it.
  Assumes a 50 ns clock; the post soft reset wait is cut to 20 cycles.
*/
`timescale 1ns/1ps
`define CHK(got, want) begin \
  tests_run++; \
  if ((got) !== (want)) begin \
    errors++; \
    $display("wrong value at %0t: got %h want %h", $time, got, want); \
  end \
end
module gyro_rate_data_readout_bench;
  import gyr_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [15:0] e;} gyr_row_t;
  typedef struct packed {
    logic [3:0] bw; logic [7:0] op; logic [4:0] dec; logic [16:0] rc; logic [1:0] k;
  } gyr_frow_t;
  logic clk_in = 1'b0, rst_in = 1'b1, sv = 1'b0, cv = 1'b0, cw = 1'b0, cwd = 1'b0;
  logic [15:0] sx = 16'h0000, sy = 16'h0000, sz = 16'h0000, res, v, prev;
  logic [7:0] st = 8'h00, ca = 8'h00, cd = 8'h00;
  logic [31:0] m;
  logic full_seen;
  wire sr, crdy, rv, rwait, srst_pulse;
  wire [15:0] rdata;
  wire [2:0] fs;
  int errors = 0, tests_run = 0, cycles = 0, pulses = 0;
  logic [15:0] ax [3] = '{16'h1234, 16'h8001, 16'h0000};
  gyr_row_t rows [12] = '{'{1'b0, 8'h0f, 8'h00, 16'h0000}, '{1'b0, 8'h10, 8'h00, 16'h0000},
    '{1'b0, 8'h13, 8'h00, 16'h0000}, '{1'b1, 8'h0f, 8'hfc, 16'h0000},
    '{1'b0, 8'h0f, 8'h00, 16'h0004}, '{1'b1, 8'h10, 8'hf3, 16'h0000},
    '{1'b0, 8'h10, 8'h00, 16'h0003}, '{1'b1, 8'h13, 8'hff, 16'h0000},
    '{1'b0, 8'h13, 8'h00, 16'h00c0}, '{1'b0, 8'h14, 8'h00, 16'h0000},
    '{1'b1, 8'h13, 8'h00, 16'h0000}, '{1'b1, 8'h10, 8'h00, 16'h0000}};
  gyr_frow_t fr [10] = '{'{4'h7, 8'h00, DEC_20, RECIP_20, 2'h1},
    '{4'h6, 8'h00, DEC_10, RECIP_10, 2'h1}, '{4'h5, 8'h00, DEC_20, RECIP_20, 2'h2},
    '{4'h4, 8'h00, DEC_10, RECIP_10, 2'h2}, '{4'h3, 8'h00, DEC_5, RECIP_5, 2'h1},
    '{4'h2, 8'h00, DEC_2, RECIP_2, 2'h1}, '{4'h1, 8'h00, DEC_1, RECIP_1, 2'h1},
    '{4'h8, 8'h00, 5'h00, 17'h00000, 2'h0}, '{4'h7, 8'h80, 5'h00, 17'h00000, 2'h0},
    '{4'h0, 8'h00, 5'h00, 17'h00000, 2'h0}};

  gyr_link_if gyr_link_if_i ();
  gyr_dev gyr_dev_i (.clk_in(clk_in), .rst_in(rst_in), .link(gyr_link_if_i),
    .sample_valid_in(sv), .sample_x_in(sx), .sample_y_in(sy), .sample_z_in(sz),
    .temp_in(st), .sample_ready_out(sr), .full_scale_out(fs), .soft_reset_out(srst_pulse));
  gyr_host #(.RESET_WAIT_CYCLES(20)) gyr_host_i (.clk_in(clk_in), .rst_in(rst_in),
    .link(gyr_link_if_i), .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_word_in(cwd),
    .cmd_addr_in(ca), .cmd_wdata_in(cd), .cmd_ready_out(crdy), .result_valid_out(rv),
    .result_data_out(rdata), .reset_wait_out(rwait));
  gyr_link_chk gyr_link_chk_i (.clk_in(clk_in), .rst_in(rst_in),
    .req_valid(gyr_link_if_i.req_valid), .req_write(gyr_link_if_i.req_write),
    .req_addr(gyr_link_if_i.req_addr), .req_wdata(gyr_link_if_i.req_wdata),
    .rsp_valid(gyr_link_if_i.rsp_valid), .rsp_data(gyr_link_if_i.rsp_data),
    .protocol_select(gyr_link_if_i.protocol_select));

  always #25 clk_in = ~clk_in;
  always @(negedge clk_in) if (srst_pulse === 1'b1) pulses++;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d, comparisons %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one host command; reads leave the result in res
  task automatic cmd(input logic w, input logic wd, input logic [7:0] a, input logic [7:0] d);
    while (crdy !== 1'b1) @(negedge clk_in);
    cv = 1'b1;
    cw = w;
    cwd = wd;
    ca = a;
    cd = d;
    @(negedge clk_in);
    cv = 1'b0;
    @(negedge clk_in);
    if (!w) begin
      while (rv !== 1'b1) @(negedge clk_in);
      res = rdata;
    end
  endtask

  // one front-end sample, then time for it to be published
  task automatic push(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    while (sr !== 1'b1) @(negedge clk_in);
    sv = 1'b1;
    sx = x;
    sy = y;
    sz = z;
    st = x[15:8];
    @(negedge clk_in);
    sv = 1'b0;
    repeat (6) @(negedge clk_in);
  endtask

  initial begin
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    foreach (rows[i]) begin
      cmd(rows[i].w, 1'b0, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK(res, rows[i].e)
    end
    for (int c = 0; c < 8; c++) begin
      cmd(1'b1, 1'b0, 8'h0f, {5'h1f, 3'(c)});
      cmd(1'b0, 1'b0, 8'h0f, 8'h00);
      `CHK(res, 16'(c))
      `CHK(fs, 3'(c))
    end
    push(16'h1234, 16'h8001, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      cmd(1'b0, 1'b1, 8'(2 + 2 * i), 8'h00);
      `CHK(res, ax[i])
    end
    cmd(1'b0, 1'b0, 8'h08, 8'h00);
    `CHK(res, 16'h0012)
    // low byte of x locks its high byte only
    cmd(1'b0, 1'b0, 8'h02, 8'h00);
    push(16'habcd, 16'h5678, 16'h0000);
    cmd(1'b0, 1'b0, 8'h05, 8'h00);
    `CHK(res, 16'h0056)
    cmd(1'b0, 1'b0, 8'h03, 8'h00);
    `CHK(res, 16'h0012)
    push(16'habcd, 16'h5678, 16'h0000);
    cmd(1'b0, 1'b0, 8'h03, 8'h00);
    `CHK(res, 16'h00ab)
    cmd(1'b1, 1'b0, 8'h13, 8'h40);
    cmd(1'b0, 1'b0, 8'h02, 8'h00);
    push(16'h2468, 16'h0000, 16'h0000);
    cmd(1'b0, 1'b0, 8'h03, 8'h00);
    `CHK(res, 16'h0024)
    // back-to-back samples until the buffer refuses
    full_seen = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      while (sr !== 1'b1) begin
        full_seen = 1'b1;
        @(negedge clk_in);
      end
      sv = 1'b1;
      sx = 16'(i);
      @(negedge clk_in);
    end
    sv = 1'b0;
    repeat (20) @(negedge clk_in);
    `CHK(full_seen, 1'b1)
    cmd(1'b0, 1'b1, 8'h02, 8'h00);
    `CHK(res, 16'h0004)
    prev = 16'h0004;
    foreach (fr[i]) begin
      v = 16'(1000 + 300 * i);
      cmd(1'b1, 1'b0, 8'h14, SOFT_RESET_CODE);
      repeat (3) @(negedge clk_in);
      `CHK(rwait, 1'b1)
      cmd(1'b0, 1'b0, 8'h0f, 8'h00);
      `CHK(res, 16'h0000)
      cmd(1'b0, 1'b0, 8'h13, 8'h00);
      `CHK(res, 16'h0000)
      cmd(1'b1, 1'b0, 8'h10, {4'h0, fr[i].bw});
      cmd(1'b1, 1'b0, 8'h13, fr[i].op);
      if (fr[i].dec > 5'h01) begin
        repeat (fr[i].dec - 1) push(v, v, v);
        cmd(1'b0, 1'b1, 8'h02, 8'h00);
        `CHK(res, prev)
      end
      push(v, v, v);
      m = 32'(v) * 32'(fr[i].dec) * 32'(fr[i].rc);
      prev = (fr[i].dec == 5'h00) ? v : 16'((m >> 16) >> fr[i].k);
      cmd(1'b0, 1'b1, 8'h02, 8'h00);
      `CHK(res, prev)
    end
    `CHK(pulses, 10)
    cmd(1'b1, 1'b0, 8'h10, 8'h03);
    rst_in = 1'b1;
    @(negedge clk_in);
    rst_in = 1'b0;
    cmd(1'b0, 1'b0, 8'h10, 8'h00);
    `CHK(res, 16'h0000)
    test_done();
  end
endmodule
